// ==== logic/sleep_clock_gating_ctrl.sv ====
// The implementer's own choices: the APB slave port and the address map.
`timescale 1ns/10ps
`default_nettype none
`include "sleep_clk_consts.svh"
module sleep_clock_gating_ctrl
  import sleep_clk_pkg::*;
#(
  parameter int WAKE_CYC = `STBY_WAKE_CYC
)
(
  // clock, reset, enable
  input wire logic pclk,
  input wire logic presetn,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // core sleep request and wake sources
  input wire logic sleep_exec,
  input wire wake_src_t wake_src,
  // peripheral register access requests
  input wire mod_en_t periph_access,
  // gating outputs
  output clk_en_t domain_en,
  output mod_en_t module_en,
  output mod_en_t periph_access_ok,
  output logic lcd_sync_en,
  output logic tmr2_sync_en,
  output logic cpu_running
);

  // the resume counter is eight bits wide
  if (WAKE_CYC < 1 || WAKE_CYC > 255)
  begin : g_bad_wake_cyc
    $error("WAKE_CYC out of range");
  end

  logic [7:0] sc_q;
  logic [7:0] pr_q;
  pstate_t st_q;
  logic [2:0] mode_q;
  logic [7:0] cnt_q;
  logic wr_en;
  logic wake;
  logic lcd_async;
  logic t2_async;
  logic any_async;
  logic any_sync;
  logic [2:0] sel_mode;
  clk_en_t dom_d;
  mod_en_t mod_d;
  logic mods_on;
  logic [4:0] mod_run;
  logic [31:0] rdata_d;
  logic rerr_d;

  assign wr_en = psel && penable && pwrite && clk_en;
  assign sel_mode = sc_q[`SC_MODE_LSB +: 3];
  assign lcd_async = sc_q[`SC_LCD_ASYNC_BIT];
  assign t2_async = sc_q[`SC_TMR2_ASYNC_BIT];
  assign any_async = lcd_async || t2_async;
  assign any_sync = !lcd_async || !t2_async;
  // module clocks only run while awake or idling
  assign mods_on = st_q == ST_ACTIVE || mode_q == `MODE_IDLE;
  for (genvar i = 0; i < 5; i++)
  begin : g_mod_run
    assign mod_run[i] = mods_on && !pr_q[i];
  end


  // sleep control register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sc_q <= `SC_RESET;
    else if (wr_en && paddr == `OFF_SLEEP_CTRL && pstrb[0])
      sc_q <= pwdata[7:0];
  end

  // power reduction register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      pr_q <= `PR_RESET;
    else if (wr_en && paddr == `OFF_PWR_RED && pstrb[0])
      pr_q <= pwdata[7:0] & `PR_WMASK;
  end

  // wake qualification per mode
  always_comb
  begin
    wake = 1'b0;
    case (mode_q)
      `MODE_IDLE:
        wake = |wake_src;
      `MODE_ADCNR:
        wake = wake_src.ext_irq_level || wake_src.pin_change
          || wake_src.start_cond || wake_src.spm_ready
          || wake_src.conv_done
          || (any_async && (wake_src.lcd_irq
          || wake_src.tmr2_irq));
      `MODE_PSAVE:
        wake = wake_src.ext_irq_level || wake_src.pin_change
          || wake_src.start_cond || wake_src.lcd_irq
          || wake_src.tmr2_irq;
      default:
        wake = wake_src.ext_irq_level || wake_src.pin_change
          || wake_src.start_cond;
    endcase
  end

  // sleep state machine
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= ST_ACTIVE;
      mode_q <= `MODE_IDLE;
      cnt_q <= 8'h00;
    end
    else if (clk_en)
    begin
      case (st_q)
        ST_ACTIVE:
          if (sleep_exec && sc_q[`SC_ENABLE_BIT])
          begin
            // reserved codes and standby without crystal are ignored
            if (sel_mode == `MODE_STBY)
            begin
              if (sc_q[`SC_XTAL_BIT])
              begin
                mode_q <= sel_mode;
                st_q <= ST_SLEEP;
              end
            end
            else if (sel_mode[2] == 1'b0)
            begin
              mode_q <= sel_mode;
              st_q <= ST_SLEEP;
            end
          end
        ST_SLEEP:
          if (wake)
          begin
            // standby waits out the resume count before running again
            if (mode_q == `MODE_STBY)
            begin
              cnt_q <= 8'(WAKE_CYC - 1);
              st_q <= ST_WAKE;
            end
            else
              st_q <= ST_ACTIVE;
          end
        ST_WAKE:
          if (cnt_q == 8'h00)
            st_q <= ST_ACTIVE;
          else
            cnt_q <= cnt_q - 8'h01;
        default:
          st_q <= ST_ACTIVE;
      endcase
    end
  end

  // domain and module enables per state
  always_comb
  begin
    dom_d = '1;
    mod_d = mod_run;
    if (st_q != ST_ACTIVE)
    begin
      dom_d.cpu = 1'b0;
      dom_d.flash = 1'b0;
      case (mode_q)
        `MODE_IDLE: ;
        `MODE_ADCNR:
        begin
          dom_d.io = 1'b0;
          dom_d.timer_osc = any_async;
          mod_d = '0;
        end
        `MODE_PSAVE:
        begin
          dom_d.io = 1'b0;
          dom_d.adc = 1'b0;
          dom_d.asy = any_async;
          dom_d.timer_osc = any_async;
          dom_d.main_osc = any_sync;
          mod_d = '0;
        end
        `MODE_STBY:
        begin
          dom_d = '0;
          dom_d.main_osc = 1'b1;
          mod_d = '0;
        end
        default:
        begin
          dom_d = '0;
          mod_d = '0;
        end
      endcase
    end
  end

  // registered gating outputs
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      domain_en <= '1;
      module_en <= '1;
      periph_access_ok <= '0;
      lcd_sync_en <= 1'b1;
      tmr2_sync_en <= 1'b1;
      cpu_running <= 1'b1;
    end
    else if (clk_en)
    begin
      domain_en <= dom_d;
      module_en <= mod_d;
      periph_access_ok <= periph_access & mod_d;
      // sync clock reaches lcd and timer2 only when they select it
      lcd_sync_en <= !lcd_async
        && (st_q == ST_ACTIVE || mode_q == `MODE_IDLE
        || mode_q == `MODE_PSAVE);
      tmr2_sync_en <= !t2_async
        && (st_q == ST_ACTIVE || mode_q == `MODE_IDLE
        || mode_q == `MODE_PSAVE);
      cpu_running <= dom_d.cpu;
    end
  end

  // read mux, captured in the setup cycle
  always_comb
  begin
    rdata_d = 32'h0000_0000;
    rerr_d = 1'b0;
    case (paddr)
      `OFF_SLEEP_CTRL:
        rdata_d = {24'h00_0000, sc_q};
      `OFF_PWR_RED:
        rdata_d = {27'h000_0000, pr_q[4:0]};
      `OFF_STATUS:
        rdata_d = {27'h000_0000, mode_q, st_q[1:0]};
      default:
        rerr_d = 1'b1;
    endcase
  end

  // apb read and answer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else if (clk_en)
    begin
      // answer in the access cycle that follows every setup cycle in which clk_en is high
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable)
      begin
        prdata <= rdata_d;
        pslverr <= rerr_d;
      end
    end
  end

endmodule : sleep_clock_gating_ctrl
`default_nettype wire

// ==== inc/sleep_clk_consts.svh ====
`ifndef SLEEP_CLK_CONSTS_SVH
`define SLEEP_CLK_CONSTS_SVH
// register byte offsets on the apb bus
`define OFF_SLEEP_CTRL 12'h000
`define OFF_PWR_RED 12'h004
`define OFF_STATUS 12'h008
// sleep control fields
`define SC_ENABLE_BIT 0
`define SC_MODE_LSB 1
`define SC_LEVEL_IRQ_BIT 4
`define SC_LCD_ASYNC_BIT 5
`define SC_TMR2_ASYNC_BIT 6
`define SC_XTAL_BIT 7
`define SC_SLEEP_BIT 8
// power reduction fields
`define PR_CONV_BIT 0
`define PR_UART_BIT 1
`define PR_SPI_BIT 2
`define PR_TMR1_BIT 3
`define PR_LCD_BIT 4
`define PR_WMASK 8'h1f
`define PR_RESET 8'h00
`define SC_RESET 8'h00
// sleep mode codes
`define MODE_IDLE 3'h0
`define MODE_ADCNR 3'h1
`define MODE_PDOWN 3'h2
`define MODE_PSAVE 3'h3
`define MODE_STBY 3'h6
// standby wake latency in main clock cycles
`define STBY_WAKE_CYC 6
`endif

// ==== inc/sleep_clk_pkg.sv ====
package sleep_clk_pkg;
  typedef enum logic [2:0] {
    ST_ACTIVE = 3'h0,
    ST_SLEEP = 3'h1,
    ST_WAKE = 3'h3
  } pstate_t;
  typedef struct packed {
    logic cpu;
    logic flash;
    logic io;
    logic adc;
    logic asy;
    logic main_osc;
    logic timer_osc;
  } clk_en_t;
  typedef struct packed {
    logic lcd;
    logic tmr1;
    logic spi;
    logic uart;
    logic conv;
  } mod_en_t;
  typedef struct packed {
    logic ext_irq_level;
    logic ext_irq_edge;
    logic pin_change;
    logic start_cond;
    logic lcd_irq;
    logic tmr2_irq;
    logic spm_ready;
    logic conv_done;
    logic other_io;
  } wake_src_t;
endpackage : sleep_clk_pkg

// ==== verif/sleep_clk_props.sv ====
`timescale 1ns/10ps
`default_nettype none
module sleep_clk_props
  import sleep_clk_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  // sleep and gating
  input wire wake_src_t wake_src,
  input wire mod_en_t periph_access,
  input wire clk_en_t domain_en,
  input wire mod_en_t module_en,
  input wire mod_en_t periph_access_ok,
  input wire logic cpu_running
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_ready_access: assert property (pready |-> psel && penable)
    else $error("pready outside access");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  a_idle_halt: assert property (!domain_en.cpu |-> !domain_en.flash
    && (!domain_en.io || domain_en[4:0] == 5'h1f))
    else $error("flash runs in sleep");
  a_deep_mods: assert property (!domain_en.io |-> module_en == 5'h00)
    else $error("module clock on in deep sleep");
  a_ok_req: assert property ($past(presetn) |->
    (periph_access_ok & ~$past(periph_access)) == 5'h00)
    else $error("access granted unasked");
  a_osc_main: assert property (!domain_en.main_osc |-> !domain_en.cpu)
    else $error("cpu runs without main clock");
  a_edge_ignored: assert property (
    (domain_en == 7'h00 && wake_src == 9'h080) [*2] |=> !cpu_running)
    else $error("edge irq woke deep sleep");
  c_sleep: cover property (!cpu_running);
  c_err: cover property (pslverr);
  c_stby: cover property (domain_en == 7'h02);
endmodule : sleep_clk_props
`default_nettype wire

// ==== verif/periph_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module periph_model
  import sleep_clk_pkg::*;
(
  // clock
  input wire logic pclk,
  // gated modules
  input wire mod_en_t module_en,
  input wire logic tmr1_on,
  output mod_en_t periph_access,
  output logic [7:0] tmr1_cnt = 8'h00
);
  // every module keeps polling its registers
  assign periph_access = 5'h1f;
  always @(posedge pclk)
    if (module_en.tmr1 && tmr1_on)
      tmr1_cnt <= tmr1_cnt + 8'h01;
endmodule : periph_model
`default_nettype wire

// ==== verif/sleep_clock_gating_ctrl_test.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "sleep_clk_consts.svh"
module sleep_clock_gating_ctrl_test
  import sleep_clk_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, sleep_exec = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'h0;
  logic pready, pslverr, lcd_sync_en, tmr2_sync_en, cpu_running, er;
  logic clk_en = 1'b1, tmr1_on = 1'b1;
  int n_cyc, n_exp;
  wake_src_t wake_src = 9'h000;
  mod_en_t periph_access, module_en, periph_access_ok;
  clk_en_t domain_en;
  logic [7:0] tmr1_cnt, c0;
  int n_mismatch = 0, n_compared = 0;
  logic [7:0] ctl [7] = '{8'ha1, 8'ha3, 8'ha5, 8'ha7, 8'had, 8'ha9, 8'h2d};
  logic [6:0] dom [7] = '{7'h1f, 7'h0f, 7'h00, 7'h07, 7'h02, 7'h7f, 7'h7f};
  always #10 pclk = ~pclk;
  sleep_clock_gating_ctrl u_sleep_clock_gating_ctrl (
    .pclk(pclk),
    .presetn(presetn),
    .clk_en(clk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pstrb(pstrb),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sleep_exec(sleep_exec),
    .wake_src(wake_src),
    .periph_access(periph_access),
    .domain_en(domain_en),
    .module_en(module_en),
    .periph_access_ok(periph_access_ok),
    .lcd_sync_en(lcd_sync_en),
    .tmr2_sync_en(tmr2_sync_en),
    .cpu_running(cpu_running)
  );
  periph_model u_periph_model (
    .pclk(pclk),
    .module_en(module_en),
    .tmr1_on(tmr1_on),
    .periph_access(periph_access),
    .tmr1_cnt(tmr1_cnt)
  );
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic tk(input int k);
    repeat (k) @(posedge pclk);
  endtask : tk
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic stop_test;
    $display("compared %0d mismatches %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : stop_test
  initial
  begin
    #400000;
    n_mismatch++;
    stop_test();
  end
  initial
  begin
    tk(8);
    presetn <= 1'b1;
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    apb(1'b1, 12'h004, 32'hff);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h1f);
    apb(1'b0, 12'hffc, 32'h0);
    chk(er, 1'b1);
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b1, 12'h004, 32'h1 << i);
      tk(3);
      c0 = tmr1_cnt;
      tk(3);
      chk(module_en, 5'h1f ^ (5'h01 << i));
      chk(periph_access_ok, 5'h1f ^ (5'h01 << i));
      chk(tmr1_cnt === c0, i == 3);
    end
    apb(1'b1, 12'h004, 32'h0);
    c0 = tmr1_cnt;
    tk(3);
    chk(tmr1_cnt != c0, 1'b1);
    tmr1_on <= 1'b0;
    apb(1'b1, 12'h004, 32'h08);
    for (int j = 0; j < 7; j++)
    begin
      apb(1'b1, 12'h000, {24'h0, ctl[j]});
      @(posedge pclk);
      sleep_exec <= 1'b1;
      @(posedge pclk);
      sleep_exec <= 1'b0;
      tk(3);
      chk(domain_en, dom[j]);
      chk(module_en, dom[j][4] ? 5'h17 : 5'h00);
      if (j == 3)
        chk({lcd_sync_en, tmr2_sync_en}, 2'b01);
      apb(1'b0, 12'h008, 32'h0);
      chk(rd, j < 5 ? {27'h0, ctl[j][3:1], 2'b01} : 32'h18);
      wake_src <= 9'h080;
      tk(3);
      chk(cpu_running, j == 0 || j > 4);
      wake_src <= 9'h100;
      n_exp = (j == 4) ? `STBY_WAKE_CYC + 3 : 3;
      if (j == 0 || j > 4)
        n_exp = 0;
      n_cyc = 0;
      while (cpu_running !== 1'b1 && n_cyc < 40)
      begin
        @(posedge pclk);
        n_cyc++;
      end
      chk(n_cyc, n_exp);
      tk(5);
      chk(cpu_running, 1'b1);
      wake_src <= 9'h000;
    end
    apb(1'b1, 12'h000, {24'h0, ctl[2]});
    clk_en <= 1'b0;
    sleep_exec <= 1'b1;
    @(posedge pclk);
    sleep_exec <= 1'b0;
    tk(3);
    chk(cpu_running, 1'b1);
    clk_en <= 1'b1;
    tk(3);
    chk(domain_en, 7'h7f);
    presetn <= 1'b0;
    tk(2);
    presetn <= 1'b1;
    chk(module_en, 5'h1f);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 32'h0);
    stop_test();
  end
endmodule : sleep_clock_gating_ctrl_test
bind sleep_clock_gating_ctrl sleep_clk_props u_sleep_clk_props (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pready(pready),
  .pslverr(pslverr),
  .wake_src(wake_src),
  .periph_access(periph_access),
  .domain_en(domain_en),
  .module_en(module_en),
  .periph_access_ok(periph_access_ok),
  .cpu_running(cpu_running)
);
`default_nettype wire
